// ==== hdl/reset_strap_config_latch.sv ====
// What this block does
// - capture strap byte as reset releases
// - host bus outputs floating until captured
// - row strobe, output enable inactive in reset
// - never drive memory data during reset
// - only bits four to zero matter
// - bit four picks pci or vl
// - bits three two give board type
// - frame buffer codes 01,10 illegal
//
// Purpose: latch power-on configuration from the memory data bus
// Assumes: memory_data_bus input synchronous to hclk
// Notes: capture uses the first edge after hresetn rises
`timescale 1ns/1ps
`default_nettype none
`include "strap_cfg_defs.svh"

module reset_strap_config_latch (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // memory data bus, sampled straps
  input wire logic [7:0] memory_data_bus,
  output logic memory_data_oe,
  // memory strobes, active low
  output logic row_strobe_n,
  output logic mem_out_enable_n,
  // host bus output enable
  output logic host_bus_oe,
  // captured configuration
  output strap_cfg_pkg::bus_type_t bus_type,
  output strap_cfg_pkg::board_type_t board_type,
  output strap_cfg_pkg::fb_type_t fb_type,
  output logic cfg_valid,
  output logic fb_illegal,
  // ahb-lite register bus
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);
  import strap_cfg_pkg::*;

  typedef enum logic [0:0] {
    st_wait,
    st_run
  } state_t;

  state_t state_r;
  state_t state_nxt;
  logic [4:0] cfg_r;
  logic [4:0] cfg_nxt;
  logic [7:0] raw_r;
  logic captured_r;
  logic illegal_r;
  logic bus_oe_r;
  logic row_n_r;
  logic oe_n_r;
  logic mem_oe_r;
  bus_type_t bus_type_r;
  board_type_t board_type_r;
  fb_type_t fb_type_r;

  // ****************************************
  // field helpers
  // ****************************************
  // reserved bits 7:5 are masked here for the fields; the raw copy still keeps all eight bits
  function automatic logic [4:0] keep_used(input logic [7:0] strap);
    logic [7:0] kept;
    kept = strap & `CFG_USED_MASK;
    keep_used = kept[4:0];
  endfunction

  function automatic logic fb_code_bad(input logic [1:0] code);
    fb_code_bad = (code == 2'b01) || (code == 2'b10);
  endfunction

  function automatic logic bus_field(input logic [4:0] cfg);
    bus_field = cfg[`CFG_BUS_BIT];
  endfunction

  function automatic logic [1:0] board_field(input logic [4:0] cfg);
    board_field = cfg[`CFG_BOARD_HI:`CFG_BOARD_LO];
  endfunction

  function automatic logic [1:0] fb_field(input logic [4:0] cfg);
    fb_field = cfg[`CFG_FB_HI:`CFG_FB_LO];
  endfunction

  function automatic logic [31:0] pack_status(
    input logic bad,
    input logic done,
    input logic [4:0] cfg
  );
    pack_status = 32'h00000000;
    pack_status[`ST_ILLEGAL_BIT] = bad;
    pack_status[`ST_CAPTURED_BIT] = done;
    pack_status[4:0] = cfg;
  endfunction

  function automatic logic [31:0] pack_raw(input logic [7:0] strap);
    pack_raw = {24'h000000, strap};
  endfunction

  // ****************************************
  // capture control
  // ****************************************
  // one capture per reset release; hresetn low clears state to wait
  // straps must stand steady across the first edge after release
  // reset is async, so even a short pulse forces a new capture
  wire capture = (state_r == st_wait);
  wire [4:0] used_bits = keep_used(memory_data_bus);

  always_comb begin
    state_nxt = state_r;
    cfg_nxt = cfg_r;
    case (state_r)
      st_wait: begin
        cfg_nxt = used_bits;
        state_nxt = st_run;
      end
      st_run: begin
        cfg_nxt = cfg_r;
      end
      default: begin
        state_nxt = st_wait;
      end
    endcase
  end

  // ****************************************
  // next values of the flags and the raw copy
  // ****************************************
  logic captured_nxt;
  logic illegal_nxt;
  logic [7:0] raw_nxt;
  logic bus_oe_nxt;

  // flags only move on the capture edge, then hold until reset
  assign captured_nxt = captured_r | capture;
  assign illegal_nxt = capture ? fb_code_bad(fb_field(used_bits))
                               : illegal_r;
  assign raw_nxt = capture ? memory_data_bus : raw_r;
  // host side leaves high impedance with the capture edge
  assign bus_oe_nxt = captured_r | capture;

  // ****************************************
  // state and configuration registers
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= st_wait;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_r <= `CFG_RESET_VAL;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      raw_r <= 8'h00;
    end else begin
      raw_r <= raw_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      captured_r <= 1'b0;
    end else begin
      captured_r <= captured_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      illegal_r <= 1'b0;
    end else begin
      illegal_r <= illegal_nxt;
    end
  end

  // ****************************************
  // field output registers
  // ****************************************
  // loaded from cfg_nxt so the fields move on the same edge as cfg_r
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_type_r <= bus_type_t'(bus_field(`CFG_RESET_VAL));
    end else begin
      bus_type_r <= bus_type_t'(bus_field(cfg_nxt));
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      board_type_r <= board_type_t'(board_field(`CFG_RESET_VAL));
    end else begin
      board_type_r <= board_type_t'(board_field(cfg_nxt));
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fb_type_r <= fb_type_t'(fb_field(`CFG_RESET_VAL));
    end else begin
      fb_type_r <= fb_type_t'(fb_field(cfg_nxt));
    end
  end

  // ****************************************
  // pin control during reset
  // ****************************************
  // strobes idle high and host bus floats until capture has happened
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_oe_r <= 1'b0;
    end else begin
      bus_oe_r <= bus_oe_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      row_n_r <= 1'b1;
    end else begin
      row_n_r <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      oe_n_r <= 1'b1;
    end else begin
      oe_n_r <= 1'b1;
    end
  end

  // straps or rom own the bus; this block never drives it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_oe_r <= 1'b0;
    end else begin
      mem_oe_r <= 1'b0;
    end
  end

  assign memory_data_oe = mem_oe_r;
  assign host_bus_oe = bus_oe_r;
  assign row_strobe_n = row_n_r;
  assign mem_out_enable_n = oe_n_r;

  // ****************************************
  // decoded fields
  // ****************************************
  assign bus_type = bus_type_r;
  assign board_type = board_type_r;
  assign fb_type = fb_type_r;
  assign cfg_valid = captured_r;
  assign fb_illegal = illegal_r;

  // ****************************************
  // register bus
  // ****************************************
  // read-only copies of the latched state; writes have no target
  wire [31:0] status_word = pack_status(illegal_r, captured_r, cfg_r);
  wire [31:0] raw_word = pack_raw(raw_r);
  wire unused_ok = ^{hsize, hwdata};

  cfg_ahb_slave u_regs (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .status_word(status_word),
    .raw_word(raw_word)
  );

endmodule
`default_nettype wire

// ==== hdl/strap_cfg_defs.svh ====
// Purpose: constants for the reset strap configuration latch
// Assumes: 32-bit AHB-Lite register bus, word aligned registers
// Notes: offsets are byte addresses
`ifndef STRAP_CFG_DEFS_SVH
`define STRAP_CFG_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define CFG_STATUS_OFFSET 12'h000
`define CFG_RAW_OFFSET 12'h004
`define CFG_ID_OFFSET 12'h008

// ****************************************
// field positions in the strap byte
// ****************************************
`define CFG_BUS_BIT 4
`define CFG_BOARD_HI 3
`define CFG_BOARD_LO 2
`define CFG_FB_HI 1
`define CFG_FB_LO 0
`define CFG_USED_MASK 8'h1f

// ****************************************
// status word bit positions
// ****************************************
`define ST_CAPTURED_BIT 8
`define ST_ILLEGAL_BIT 9

// ****************************************
// reset values
// ****************************************
`define CFG_RESET_VAL 5'h00
// identity word: value is arbitrary
`define CFG_ID_VAL 32'h00c0ffee

`endif

// ==== hdl/strap_cfg_pkg.sv ====
// Purpose: types for the reset strap configuration latch
// Assumes: nothing beyond the defs header
// Notes: encodings follow the strap byte layout
package strap_cfg_pkg;

  typedef enum logic {
    bus_pci = 1'b0,
    bus_vl = 1'b1
  } bus_type_t;

  typedef enum logic [1:0] {
    board_mother = 2'b00,
    board_adapter1 = 2'b01,
    board_adapter2 = 2'b10,
    board_adapter3 = 2'b11
  } board_type_t;

  typedef enum logic [1:0] {
    fb_vram = 2'b00,
    fb_bad1 = 2'b01,
    fb_bad2 = 2'b10,
    fb_dram = 2'b11
  } fb_type_t;

endpackage

// ==== hdl/cfg_ahb_slave.sv ====
// Purpose: AHB-Lite read-only register slave for captured configuration
// Assumes: single word transfers, zero wait states
// Notes: writes are accepted and ignored; unmapped reads give zero
`timescale 1ns/1ps
`default_nettype none
`include "strap_cfg_defs.svh"

module cfg_ahb_slave (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // register contents
  input wire logic [31:0] status_word,
  input wire logic [31:0] raw_word
);

  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic ready_r;
  logic resp_r;
  wire take = hsel & hready & htrans[1] & ~hwrite;

  // ****************************************
  // read data selection
  // ****************************************
  // decoded in the address phase so read data leaves a flop
  wire hit_status = (haddr == `CFG_STATUS_OFFSET);
  wire hit_raw = (haddr == `CFG_RAW_OFFSET);
  wire hit_id = (haddr == `CFG_ID_OFFSET);

  always_comb begin
    if (!take) begin
      rdata_nxt = 32'h00000000;
    end else if (hit_status) begin
      rdata_nxt = status_word;
    end else if (hit_raw) begin
      rdata_nxt = raw_word;
    end else if (hit_id) begin
      rdata_nxt = `CFG_ID_VAL;
    end else begin
      rdata_nxt = 32'h00000000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_r <= 32'h00000000;
      ready_r <= 1'b1;
      resp_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      ready_r <= 1'b1;
      resp_r <= 1'b0;
    end
  end

  assign hreadyout = ready_r;
  assign hresp = resp_r;
  assign hrdata = rdata_r;

endmodule
`default_nettype wire

// ==== test/strap_source.sv ====
// Purpose: strap resistors or rom on the memory data bus
// Assumes: the device never drives the bus
// Notes: illegal codes appear only when the bench asks
`timescale 1ns/1ps
`default_nettype none
module strap_source (
  // wanted level
  input wire logic [7:0] strap_byte,
  // memory data bus
  output logic [7:0] memory_data_bus
);
  // resistors keep their level, so the byte stands after reset too
  assign memory_data_bus = strap_byte;
endmodule
`default_nettype wire

// ==== test/strap_cfg_sva.sv ====
// Purpose: port checks for the strap latch
// Assumes: one clock, async low reset
// Notes: bound from the bench top
`timescale 1ns/1ps
`default_nettype none
module strap_cfg_sva (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // memory side
  input wire logic [7:0] memory_data_bus,
  input wire logic memory_data_oe,
  input wire logic row_strobe_n,
  input wire logic mem_out_enable_n,
  // host side
  input wire logic host_bus_oe,
  input wire strap_cfg_pkg::bus_type_t bus_type,
  input wire strap_cfg_pkg::board_type_t board_type,
  input wire strap_cfg_pkg::fb_type_t fb_type,
  input wire logic cfg_valid,
  input wire logic fb_illegal
);
  import strap_cfg_pkg::*;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_CAPTURE: assert property ($rose(hresetn) |=> cfg_valid &&
    {bus_type, board_type, fb_type} == $past(memory_data_bus[4:0]))
    else $error("bad capture");
  AST_HOST_FLOAT: assert property ($rose(hresetn) |->
    !host_bus_oe ##1 host_bus_oe) else $error("host oe");
  AST_STROBES: assert property ($rose(hresetn) |->
    row_strobe_n && mem_out_enable_n) else $error("strobe");
  AST_NO_DRIVE: assert property ($rose(hresetn) |->
    !memory_data_oe && !$past(memory_data_oe)) else $error("bus driven");
  AST_BUS_BIT: assert property ($rose(hresetn) ##1 1'b1 |->
    bus_type == $past(memory_data_bus[4])) else $error("bus type");
  AST_BOARD: assert property (cfg_valid && !$past(cfg_valid) |->
    board_type == $past(memory_data_bus[3:2])) else $error("board");
  AST_FB_FLAG: assert property (cfg_valid |-> fb_illegal == ^fb_type)
    else $error("fb flag");
  AST_HOLD: assert property ($past(cfg_valid) |->
    $stable({bus_type, board_type, fb_type})) else $error("moved");
endmodule
`default_nettype wire

// ==== test/tb_reset_strap_config_latch.sv ====
// Purpose: bench for the strap latch
// Assumes: hreadyout feeds hready
// Notes: rows hold strap byte beside expected fields
`timescale 1ns/1ps
`default_nettype none
`include "strap_cfg_defs.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin errors++; \
$display("wrong value at %0t: %h %h", $time, a, e); end end
module tb_reset_strap_config_latch;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rdy_q = 0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [11:0] haddr = 12'h0;
  logic [31:0] hwdata = 32'h0, hrdata, rd_q, d;
  logic [7:0] strap_byte = 8'h0, memory_data_bus;
  logic memory_data_oe, row_strobe_n, mem_out_enable_n, host_bus_oe;
  logic cfg_valid, fb_illegal, hreadyout, hresp;
  strap_cfg_pkg::bus_type_t bus_type;
  strap_cfg_pkg::board_type_t board_type;
  strap_cfg_pkg::fb_type_t fb_type;
  int errors = 0, compares = 0;
  logic [12:0] rows [5] = '{{8'h00, 5'h00}, {8'he5, 5'h05},
    {8'h1a, 5'h1a}, {8'h7f, 5'h1f}, {8'h8c, 5'h0c}};
  always #5 hclk = ~hclk;
  // copies taken at the edge, before the slave moves on
  always @(posedge hclk) begin
    rdy_q <= hreadyout;
    rd_q <= hrdata;
  end
  strap_source i_strap_source (.*);
  reset_strap_config_latch i_reset_strap_config_latch (.hready(hreadyout), .*);
  task automatic give_verdict;
    if (errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wt;
    int n = 0;
    do begin
      @(posedge hclk);
      #1;
      n++;
    end while (rdy_q !== 1'b1 && n < 20);
    if (rdy_q !== 1'b1) begin
      errors++;
      give_verdict;
    end
  endtask
  task automatic ahb(input logic w, input logic [11:0] a);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wt;
    htrans <= 2'h0;
    hwdata <= 32'hffff_ffff;
    wt;
    d = rd_q;
    hsel <= 1'b0;
  endtask
  initial begin
    repeat (12) @(posedge hclk);
    `CHK({host_bus_oe, cfg_valid, memory_data_oe}, 3'h0)
    `CHK({row_strobe_n, mem_out_enable_n}, 2'h3)
    foreach (rows[i]) begin
      @(posedge hclk);
      hresetn <= 1'b0;
      strap_byte <= rows[i][12:5];
      @(posedge hclk);
      hresetn <= 1'b1;
      repeat (3) @(posedge hclk);
      #1;
      `CHK({bus_type, board_type, fb_type}, rows[i][4:0])
      `CHK({fb_illegal, host_bus_oe}, {^rows[i][1:0], 1'b1})
      strap_byte <= ~rows[i][12:5];
      ahb(1'b0, `CFG_STATUS_OFFSET);
      `CHK(d, {22'h0, ^rows[i][1:0], 1'b1, 3'h0, rows[i][4:0]})
      ahb(1'b0, `CFG_RAW_OFFSET);
      `CHK(d, {24'h0, rows[i][12:5]})
    end
    ahb(1'b1, `CFG_STATUS_OFFSET);
    ahb(1'b0, `CFG_STATUS_OFFSET);
    `CHK(d, 32'h0000_010c)
    ahb(1'b0, 12'h00c);
    `CHK(d, 32'h0)
    ahb(1'b0, `CFG_ID_OFFSET);
    `CHK(d, `CFG_ID_VAL)
    `CHK(hresp, 1'b0)
    give_verdict;
  end
endmodule
bind reset_strap_config_latch strap_cfg_sva i_strap_cfg_sva (.*);
`default_nettype wire
